// ==== hdl/eee_pkg.sv ====
// Constants and types shared by the low-power-idle control block
package eee_pkg;
  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int REF_PERIOD_PS = 5000; // System clock period
  localparam int US_PS = 1000000; // One microsecond
  localparam logic [7:0] US_CYC = 8'(US_PS / REF_PERIOD_PS);
  localparam int GTX_PERIOD_PS = 8000; // Transmit clock period
  localparam int GTX_HOLD_CLKS = 9; // Clocks after request before halt
  localparam int GTX_RESUME_CLKS = 1; // Clocks before request drops
  localparam logic [4:0] GTX_HOLD_CYC =
    5'((GTX_HOLD_CLKS * GTX_PERIOD_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS);
  localparam logic [4:0] GTX_RESUME_CYC =
    5'((GTX_RESUME_CLKS * GTX_PERIOD_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS);
  // ----------------------------------------
  // Interframe gap, 96 bit times
  // ----------------------------------------
  localparam int IFG_100_NS = 960;
  localparam int IFG_1000_NS = 96;
  localparam int TMR_W = 20; // Width of every down timer
  localparam logic [TMR_W-1:0] IFG_100_CYC =
    TMR_W'((IFG_100_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS);
  localparam logic [TMR_W-1:0] IFG_1000_CYC =
    TMR_W'((IFG_1000_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS);
  // ----------------------------------------
  // Link, receive filter, widths
  // ----------------------------------------
  localparam int LINK_HOLD_US_DEF = 1000000; // One second of link up
  localparam logic [2:0] RX_ACT_CLKS = 3'h3; // Samples to accept idle
  localparam logic [2:0] RX_IDLE_CLKS = 3'h4; // Samples to leave idle
  localparam int WAKE_W = 16; // Wake wait time, microseconds
  localparam int CNT_W = 32; // Statistics counters
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_LPI = 2'b01, TX_HALT = 2'b10, TX_RESUME = 2'b11
  } eee_tx_state_e;
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00, SRC_PAUSE = 2'b01, SRC_RESP = 2'b10, SRC_FIFO = 2'b11
  } eee_src_e;
endpackage

// ==== hdl/eee_rx_if.sv ====
// Signals between the system side and the receive-clock filter
`timescale 1ns/1ps
`default_nettype none
interface eee_rx_if;
  logic decode_en; // System domain: receive idle decoding allowed
  logic lpi_level; // Receive domain: filtered idle level
  // ----------------------------------------
  // Views
  // ----------------------------------------
  modport sys (output decode_en, input lpi_level);
  modport link (input decode_en, output lpi_level);
endinterface
`default_nettype wire

// ==== hdl/eee_down_timer.sv ====
// Loadable down counter that steps on a tick
`timescale 1ns/1ps
`default_nettype none
module eee_down_timer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic load, // Restart with load_val
  input wire logic [eee_pkg::TMR_W-1:0] load_val,
  input wire logic tick, // Step enable
  output logic busy // Count not yet zero
);
  logic [eee_pkg::TMR_W-1:0] cnt_q; // Remaining steps

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Load wins over a step so a restart never loses a count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (tick && busy) begin
      cnt_q <= cnt_q - eee_pkg::TMR_W'(1);
    end
  end

  assign busy = (cnt_q != '0);
endmodule
`default_nettype wire

// ==== hdl/eee_rx_filter.sv ====
// Receive idle filter running on the receive clock
`timescale 1ns/1ps
`default_nettype none
module eee_rx_filter (
  input wire logic rx_clk,
  input wire logic resetn,
  input wire logic phy_rx_lpi, // Idle indication, rx_clk synchronous
  eee_rx_if.link rx
);
  logic en_m_q, en_s_q; // Enable synchroniser
  logic raw_q; // Registered indication
  logic [2:0] act_q, idle_q; // Consecutive sample counts
  logic lpi_q; // Filtered level
  // Accept count and saturation point of the active run
  localparam logic [2:0] RX_ACT_M1 = eee_pkg::RX_ACT_CLKS;
  // Accept count and saturation point of the idle run
  localparam logic [2:0] RX_IDLE_M1 = eee_pkg::RX_IDLE_CLKS;

  // ----------------------------------------
  // Enable crossing
  // ----------------------------------------
  always_ff @(posedge rx_clk or negedge resetn) begin
    if (!resetn) begin
      en_m_q <= 1'b0;
      en_s_q <= 1'b0;
    end else begin
      en_m_q <= rx.decode_en;
      en_s_q <= en_m_q;
    end
  end

  // ----------------------------------------
  // Filter
  // ----------------------------------------
  // Short glitches never reach the system side
  always_ff @(posedge rx_clk or negedge resetn) begin
    if (!resetn) begin
      raw_q <= 1'b0;
      act_q <= '0;
      idle_q <= '0;
      lpi_q <= 1'b0;
    end else begin
      raw_q <= phy_rx_lpi;
      if (!en_s_q) begin
        act_q <= '0;
        idle_q <= '0;
        lpi_q <= 1'b0;
      end else if (raw_q) begin
        idle_q <= '0;
        if (act_q != RX_ACT_M1) act_q <= act_q + 3'h1;
        if (act_q == RX_ACT_M1 - 3'h1) lpi_q <= 1'b1;
      end else begin
        act_q <= '0;
        if (idle_q != RX_IDLE_M1) idle_q <= idle_q + 3'h1;
        if (idle_q == RX_IDLE_M1 - 3'h1) lpi_q <= 1'b0;
      end
    end
  end

  assign rx.lpi_level = lpi_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_rx_active_run: assert property (@(posedge rx_clk) disable iff (!resetn)
    $rose(lpi_q) |-> $past(raw_q, 1) && $past(raw_q, 2) && $past(raw_q, 3))
    else $error("idle accepted before three samples");
  a_rx_idle_run: assert property (@(posedge rx_clk) disable iff (!resetn)
    $fell(lpi_q) && $past(en_s_q) |-> !$past(raw_q, 1) && !$past(raw_q, 2)
      && !$past(raw_q, 3) && !$past(raw_q, 4))
    else $error("idle left before four samples");
endmodule
`default_nettype wire

// ==== hdl/eee_lpi_ctrl.sv ====
// Low-power-idle control: transmit request, wake deferral, receive decode
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module eee_lpi_ctrl #(
  parameter int unsigned LINK_HOLD_US = eee_pkg::LINK_HOLD_US_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_clk, // Receive clock from the phy, may stop
  input wire logic phy_rx_lpi, // Receive idle indication
  input wire logic link_up_pin, // Phy link status pin
  input wire logic energy_efficient_enable,
  input wire logic [1:0] link_speed, // 0:10, 1:100, 2:1000
  input wire logic full_duplex,
  input wire logic eee_both_adv, // Both ends advertise at this speed
  input wire logic tx_clock_halt_enable,
  input wire logic [eee_pkg::WAKE_W-1:0] tx_wake_wait_100,
  input wire logic [eee_pkg::WAKE_W-1:0] tx_wake_wait_1000,
  input wire logic client_lpi_req, // From the client empty timer
  input wire logic frame_active, // Transmitter sending a frame
  input wire logic pause_req,
  input wire logic resp_req, // Address or neighbour response
  input wire logic fifo_req,
  input wire logic rx_idle_start_irq_enable,
  input wire logic rx_wake_enable,
  input wire logic energy_wake_enable,
  input wire logic rx_idle_start_clr, // Software clear pulses
  input wire logic rx_wake_clr,
  input wire logic energy_wake_clr,
  output logic phy_tx_lpi_q, // Idle request to the phy
  output logic gtx_clk_run_q, // Transmit clock gate enable
  output logic deferring_q,
  output logic tx_allow_q, // Frame start permitted
  output eee_pkg::eee_src_e tx_src_q,
  output logic tx_src_valid_q, // One-cycle source decision
  output logic rx_lpi_active_q,
  output logic rx_idle_start_flag_q,
  output logic rx_idle_irq_q,
  output logic rx_wake_flag_q,
  output logic energy_wake_status_q,
  output logic remote_wake_req_q,
  output logic [eee_pkg::CNT_W-1:0] tx_lpi_trans_q,
  output logic [eee_pkg::CNT_W-1:0] tx_lpi_time_q,
  output logic [eee_pkg::CNT_W-1:0] rx_lpi_trans_q,
  output logic [eee_pkg::CNT_W-1:0] rx_lpi_time_q
);
  eee_rx_if rx_if ();
  eee_pkg::eee_tx_state_e st_q; // Transmit idle state
  logic [7:0] us_cnt_q; // Microsecond divider
  logic us_tick_q; // One-cycle tick
  logic link_m_q, link_s_q; // Link pin synchroniser
  logic armed_q; // Link hold timer armed after reset
  logic link_busy; // Link hold still running
  logic eee_ok; // All link conditions met
  logic decode_en_q; // To the receive domain
  logic lpi_m_q, lpi_s_q, lpi_p_q; // Receive level crossing flops and previous decoded level
  logic [4:0] gcnt_q; // System clock cycle count for transmit clock hold and resume
  logic lpi_want; // Client wants idle now
  logic carrier_q; // Carrier indication during wake
  logic wake_pend_q; // Wake timer running
  logic wake_busy;
  logic [eee_pkg::TMR_W-1:0] wake_val;
  logic ifg_pend_q; // Gap timer running
  logic ifg_busy;
  logic ifg_load;
  logic deferring_d;
  logic src_busy_q; // Decision made, frame not yet done
  logic frame_p_q; // Previous frame_active

  // ----------------------------------------
  // Microsecond tick
  // ----------------------------------------
  // Runs from the system clock so it survives halted link clocks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      us_cnt_q <= '0;
      us_tick_q <= 1'b0;
    end else if (us_cnt_q == eee_pkg::US_CYC - 8'h1) begin
      us_cnt_q <= '0;
      us_tick_q <= 1'b1;
    end else begin
      us_cnt_q <= us_cnt_q + 8'h1;
      us_tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Link condition
  // ----------------------------------------
  // Link pin is asynchronous, two flops before use
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link_m_q <= 1'b0;
      link_s_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      link_m_q <= link_up_pin;
      link_s_q <= link_m_q;
      armed_q <= 1'b1;
    end
  end

  // Hold restarts on every drop of link
  eee_down_timer u_link_hold (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(!link_s_q || !armed_q),
    .load_val(eee_pkg::TMR_W'(LINK_HOLD_US)),
    .tick(us_tick_q),
    .busy(link_busy)
  );

  // Receiver and transmitter enable bits are deliberately not inputs
  assign eee_ok = energy_efficient_enable && full_duplex && eee_both_adv
    && (link_speed == eee_pkg::SPEED_100 || link_speed == eee_pkg::SPEED_1000)
    && link_s_q && armed_q && !link_busy;

  // ----------------------------------------
  // Transmit idle request and clock gate
  // ----------------------------------------
  // Client request is only honoured between frames
  assign lpi_want = client_lpi_req && eee_ok;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= eee_pkg::TX_IDLE;
      phy_tx_lpi_q <= 1'b0;
      gtx_clk_run_q <= 1'b1;
      gcnt_q <= '0;
    end else begin
      unique case (st_q)
        eee_pkg::TX_IDLE: begin
          // Pulse that ended inside a frame is never seen here
          if (lpi_want && !frame_active && !deferring_q) begin
            st_q <= eee_pkg::TX_LPI;
            phy_tx_lpi_q <= 1'b1;
            gcnt_q <= '0;
          end
        end
        eee_pkg::TX_LPI: begin
          if (gcnt_q != eee_pkg::GTX_HOLD_CYC) gcnt_q <= gcnt_q + 5'h1;
          if (!lpi_want) begin
            // Clock is still running, so drop at once
            st_q <= eee_pkg::TX_IDLE;
            phy_tx_lpi_q <= 1'b0;
          end else if (tx_clock_halt_enable && gcnt_q == eee_pkg::GTX_HOLD_CYC) begin
            st_q <= eee_pkg::TX_HALT;
            gtx_clk_run_q <= 1'b0;
          end
        end
        eee_pkg::TX_HALT: begin
          if (!lpi_want || !tx_clock_halt_enable) begin
            st_q <= eee_pkg::TX_RESUME;
            gtx_clk_run_q <= 1'b1;
            gcnt_q <= '0;
          end
        end
        eee_pkg::TX_RESUME: begin
          gcnt_q <= gcnt_q + 5'h1;
          if (gcnt_q == eee_pkg::GTX_RESUME_CYC - 5'h1) begin
            gcnt_q <= '0;
            if (lpi_want) begin
              st_q <= eee_pkg::TX_LPI;
            end else begin
              st_q <= eee_pkg::TX_IDLE;
              phy_tx_lpi_q <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Wake timer and carrier indication
  // ----------------------------------------
  // Speed in force at the moment of the drop picks the wait
  assign wake_val = (link_speed == eee_pkg::SPEED_1000) ?
    eee_pkg::TMR_W'(tx_wake_wait_1000) : eee_pkg::TMR_W'(tx_wake_wait_100);

  eee_down_timer u_wake (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(st_q != eee_pkg::TX_IDLE && !lpi_want && phy_tx_lpi_q
      && st_q != eee_pkg::TX_HALT && (st_q == eee_pkg::TX_LPI
      || gcnt_q == eee_pkg::GTX_RESUME_CYC - 5'h1)),
    .load_val(wake_val),
    .tick(us_tick_q),
    .busy(wake_busy)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      carrier_q <= 1'b0;
      wake_pend_q <= 1'b0;
    end else if (phy_tx_lpi_q) begin
      carrier_q <= 1'b1;
      wake_pend_q <= 1'b0;
    end else if (carrier_q && !wake_pend_q) begin
      wake_pend_q <= 1'b1; // Timer was loaded on the drop
    end else if (wake_pend_q && !wake_busy) begin
      carrier_q <= 1'b0;
      wake_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Deferral and interframe gap
  // ----------------------------------------
  assign ifg_load = deferring_q && !frame_active && !carrier_q && !ifg_pend_q;

  eee_down_timer u_ifg (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(ifg_load),
    .load_val((link_speed == eee_pkg::SPEED_1000) ?
      eee_pkg::IFG_1000_CYC : eee_pkg::IFG_100_CYC),
    .tick(1'b1),
    .busy(ifg_busy)
  );

  // Gap only starts once both frame and carrier are gone
  always_comb begin
    deferring_d = deferring_q;
    if (frame_active || carrier_q) begin
      deferring_d = 1'b1;
    end else if (ifg_pend_q && !ifg_busy) begin
      deferring_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      deferring_q <= 1'b0;
      tx_allow_q <= 1'b0;
      ifg_pend_q <= 1'b0;
    end else begin
      deferring_q <= deferring_d;
      tx_allow_q <= !deferring_d && !phy_tx_lpi_q;
      if (frame_active || carrier_q || !deferring_d) ifg_pend_q <= 1'b0;
      else if (ifg_load) ifg_pend_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Transmit source selection
  // ----------------------------------------
  // Deciding late keeps a pause frame from waiting behind a long frame
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_src_q <= eee_pkg::SRC_NONE;
      tx_src_valid_q <= 1'b0;
      src_busy_q <= 1'b0;
      frame_p_q <= 1'b0;
    end else begin
      frame_p_q <= frame_active;
      tx_src_valid_q <= 1'b0;
      if (src_busy_q) begin
        if (frame_p_q && !frame_active) src_busy_q <= 1'b0;
      end else if (!carrier_q && !frame_active && !phy_tx_lpi_q
          && (pause_req || resp_req || fifo_req)) begin
        tx_src_valid_q <= 1'b1;
        src_busy_q <= 1'b1;
        if (pause_req) tx_src_q <= eee_pkg::SRC_PAUSE;
        else if (resp_req) tx_src_q <= eee_pkg::SRC_RESP;
        else tx_src_q <= eee_pkg::SRC_FIFO;
      end
    end
  end

  // ----------------------------------------
  // Receive idle decode
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      decode_en_q <= 1'b0;
    end else begin
      decode_en_q <= eee_ok;
    end
  end

  assign rx_if.decode_en = decode_en_q;

  // Filter lives on the receive clock
  eee_rx_filter u_rx_filter (
    .rx_clk(rx_clk),
    .resetn(resetn),
    .phy_rx_lpi(phy_rx_lpi),
    .rx(rx_if.link)
  );

  // Level crossing; only the second flop is looked at
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lpi_m_q <= 1'b0;
      lpi_s_q <= 1'b0;
      lpi_p_q <= 1'b0;
      rx_lpi_active_q <= 1'b0;
    end else begin
      lpi_m_q <= rx_if.lpi_level;
      lpi_s_q <= lpi_m_q;
      lpi_p_q <= rx_lpi_active_q; // Previous level, edges of the decoded idle
      rx_lpi_active_q <= lpi_s_q && decode_en_q;
    end
  end

  // ----------------------------------------
  // Receive flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_idle_start_flag_q <= 1'b0;
      rx_idle_irq_q <= 1'b0;
      rx_wake_flag_q <= 1'b0;
      energy_wake_status_q <= 1'b0;
      remote_wake_req_q <= 1'b0;
    end else begin
      if (rx_lpi_active_q && !lpi_p_q) rx_idle_start_flag_q <= 1'b1;
      else if (rx_idle_start_clr) rx_idle_start_flag_q <= 1'b0;
      rx_idle_irq_q <= rx_idle_start_flag_q && rx_idle_start_irq_enable;
      if (!rx_lpi_active_q && lpi_p_q && rx_wake_enable) rx_wake_flag_q <= 1'b1;
      else if (rx_wake_clr) rx_wake_flag_q <= 1'b0;
      if (rx_wake_flag_q) energy_wake_status_q <= 1'b1;
      else if (energy_wake_clr) energy_wake_status_q <= 1'b0;
      remote_wake_req_q <= energy_wake_status_q && energy_wake_enable;
    end
  end

  // ----------------------------------------
  // Statistics counters
  // ----------------------------------------
  // No power-state input gates these, so they run in every state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_lpi_trans_q <= '0;
      tx_lpi_time_q <= '0;
      rx_lpi_trans_q <= '0;
      rx_lpi_time_q <= '0;
    end else begin
      if (lpi_want && st_q == eee_pkg::TX_IDLE && !frame_active && !deferring_q)
        tx_lpi_trans_q <= tx_lpi_trans_q + 32'h1;
      if (phy_tx_lpi_q && us_tick_q) tx_lpi_time_q <= tx_lpi_time_q + 32'h1;
      if (rx_lpi_active_q && !lpi_p_q) rx_lpi_trans_q <= rx_lpi_trans_q + 32'h1;
      if (rx_lpi_active_q && us_tick_q) rx_lpi_time_q <= rx_lpi_time_q + 32'h1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_wake_start;
    $fell(phy_tx_lpi_q);
  endsequence

  a_lpi_after_frame: assert property ($rose(phy_tx_lpi_q) |-> !$past(frame_active))
    else $error("idle requested during a frame");
  a_lpi_needs_client: assert property ($rose(phy_tx_lpi_q) |-> $past(client_lpi_req))
    else $error("idle requested without client");
  a_wake_carrier: assert property (s_wake_start |-> carrier_q ##1 carrier_q)
    else $error("carrier missing during wake");
  a_wake_defers: assert property (s_wake_start |-> !tx_allow_q [*3])
    else $error("frame allowed right after wake");
  a_defer_blocks: assert property (tx_allow_q |-> !deferring_q)
    else $error("frame allowed while deferring");
  a_clock_hold: assert property ($rose(phy_tx_lpi_q) |-> gtx_clk_run_q [*8] ##1 gtx_clk_run_q [*7])
    else $error("transmit clock halted too early");
  a_clock_before_drop: assert property (s_wake_start |-> $past(gtx_clk_run_q, 2))
    else $error("request dropped with clock halted");
  a_tx_trans_count: assert property ($rose(phy_tx_lpi_q) |->
    tx_lpi_trans_q == $past(tx_lpi_trans_q) + 32'h1)
    else $error("transition count not incremented");
  a_src_after_wake: assert property (tx_src_valid_q |->
    !$past(carrier_q) && (tx_src_q == eee_pkg::SRC_PAUSE || !$past(pause_req)))
    else $error("source chosen wrongly");
  a_rx_start_flag: assert property ($rose(rx_lpi_active_q) |=> rx_idle_start_flag_q)
    else $error("receive idle start not flagged");
endmodule
`default_nettype wire

// ==== verif/eee_phy_model.sv ====
// Receive side of the phy: idle indication and a receive clock that may stop
`timescale 1ns/1ps
`default_nettype none
module eee_phy_model (
  input wire logic lpi_go,
  output logic rx_clk,
  output logic phy_rx_lpi
);
  logic run = 1'b1; // Clock gate, dropped only deep inside idle
  // Free clock outside idle; 12 ns period, phase unrelated to ref_clk
  initial begin
    rx_clk = 1'b0;
    #3.1;
    forever begin
      #6;
      if (run) rx_clk = ~rx_clk;
    end
  end
  // Idle episode: indication, clock stop, restart, trailing idle clocks
  initial begin
    phy_rx_lpi = 1'b0;
    forever begin
      @(posedge lpi_go);
      @(negedge rx_clk) phy_rx_lpi = 1'b1;
      repeat (10) @(negedge rx_clk);
      run = 1'b0;
      @(negedge lpi_go);
      run = 1'b1;
      repeat (2) @(negedge rx_clk);
      phy_rx_lpi = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/eee_lpi_ctrl_tb.sv ====
// Self-checking bench for the low-power-idle control block
`timescale 1ns/1ps
`default_nettype none
module eee_lpi_ctrl_tb;
  logic ref_clk, resetn, rx_clk, phy_rx_lpi, link_up_pin, energy_efficient_enable, full_duplex;
  logic eee_both_adv, tx_clock_halt_enable, client_lpi_req, frame_active, pause_req, resp_req;
  logic fifo_req, rx_idle_start_irq_enable, rx_wake_enable, energy_wake_enable, rx_idle_start_clr;
  logic rx_wake_clr, energy_wake_clr, phy_tx_lpi_q, gtx_clk_run_q, deferring_q, tx_allow_q;
  logic tx_src_valid_q, rx_lpi_active_q, rx_idle_start_flag_q, rx_idle_irq_q, rx_wake_flag_q;
  logic energy_wake_status_q, remote_wake_req_q, lpi_go;
  logic [1:0] link_speed;
  logic [eee_pkg::WAKE_W-1:0] tx_wake_wait_100, tx_wake_wait_1000;
  eee_pkg::eee_src_e tx_src_q;
  logic [eee_pkg::CNT_W-1:0] tx_lpi_trans_q, tx_lpi_time_q, rx_lpi_trans_q, rx_lpi_time_q;
  int fails = 0, n_compared = 0, cyc = 0, i, bad, g;
  eee_lpi_ctrl #(.LINK_HOLD_US(2)) uut (.*);
  eee_phy_model phy (.lpi_go(lpi_go), .rx_clk(rx_clk), .phy_rx_lpi(phy_rx_lpi));
  // ----------------------------------------
  // Clock, hang guard, helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Transmit idle: frame guard, clock halt, wake deferral, source choice
  task automatic t_tx(input logic [1:0] sp, input int w);
    logic [31:0] tr, tm;
    int lo;
    link_speed = sp;
    lo = (w - 1) * 200;
    lo += int'((sp == eee_pkg::SPEED_100) ? eee_pkg::IFG_100_CYC : eee_pkg::IFG_1000_CYC);
    tr = tx_lpi_trans_q;
    frame_active = 1'b1;
    client_lpi_req = 1'b1;
    step(4);
    client_lpi_req = 1'b0;
    step(4);
    chk(phy_tx_lpi_q, 1'b0);
    client_lpi_req = 1'b1;
    step(4);
    chk(phy_tx_lpi_q, 1'b0);
    frame_active = 1'b0;
    for (i = 0; i < 300 && !phy_tx_lpi_q; i++) step(1);
    chk(tx_lpi_trans_q, tr + 1);
    step(13);
    chk(gtx_clk_run_q, 1'b1);
    step(10);
    chk(gtx_clk_run_q, 1'b0);
    chk(tx_allow_q, 1'b0);
    chk(deferring_q, 1'b1);
    {pause_req, fifo_req} = 2'h3;
    tm = tx_lpi_time_q;
    step(600);
    chk((tx_lpi_time_q - tm) >= 2 && (tx_lpi_time_q - tm) <= 4, 1'b1);
    client_lpi_req = 1'b0;
    for (i = 0; i < 20 && phy_tx_lpi_q; i++) begin
      g = gtx_clk_run_q;
      step(1);
    end
    chk(g, 1'b1);
    // The single source decision falls at wake expiry, before the gap ends
    bad = 0;
    g = 0;
    for (i = 0; i < 3000 && !tx_allow_q; i++) begin
      bad += tx_src_valid_q;
      if (tx_src_valid_q) g = i;
      step(1);
    end
    chk(bad, 1);
    chk(g >= (w - 1) * 200 && g <= w * 200 + 10, 1'b1);
    chk(i >= lo && i <= lo + 220, 1'b1);
    chk(tx_src_q, eee_pkg::SRC_PAUSE);
    // Next frame frees the selector; a response then beats fifo data
    {pause_req, resp_req, fifo_req} = 3'h3;
    frame_active = 1'b1;
    step(2);
    frame_active = 1'b0;
    step(3);
    chk(tx_src_q, eee_pkg::SRC_RESP);
    {resp_req, fifo_req} = 2'h0;
    step(5);
    $display("tx test done at speed %0d", sp);
  endtask
  // Receive idle: gating, filter, flags, counters, clears
  task automatic t_rx();
    energy_efficient_enable = 1'b0;
    lpi_go = 1'b1;
    step(80);
    chk(rx_lpi_active_q, 1'b0);
    lpi_go = 1'b0;
    step(20);
    energy_efficient_enable = 1'b1;
    step(700);
    lpi_go = 1'b1;
    for (i = 0; i < 100 && !rx_lpi_active_q; i++) step(1);
    // Count and flag follow the decoded edge by one cycle, interrupt by two
    step(2);
    chk(rx_lpi_trans_q, 32'h1);
    chk(rx_idle_start_flag_q & rx_idle_irq_q, 1'b1);
    step(600);
    chk(rx_lpi_time_q >= 2, 1'b1);
    lpi_go = 1'b0;
    for (i = 0; i < 100 && rx_lpi_active_q; i++) step(1);
    step(3);
    chk(rx_wake_flag_q & energy_wake_status_q & remote_wake_req_q, 1'b1);
    // Status is set again while the wake flag stands, so clears last two cycles
    {rx_idle_start_clr, rx_wake_clr, energy_wake_clr} = 3'h7;
    step(2);
    {rx_idle_start_clr, rx_wake_clr, energy_wake_clr} = 3'h0;
    step(2);
    chk(rx_idle_start_flag_q | rx_wake_flag_q | energy_wake_status_q, 1'b0);
    $display("rx test done");
  endtask
  // Main sequence
  initial begin
    {resetn, link_up_pin, full_duplex, eee_both_adv, energy_efficient_enable} = 5'h0f;
    {tx_clock_halt_enable, rx_idle_start_irq_enable, rx_wake_enable, energy_wake_enable} = 4'hf;
    {client_lpi_req, frame_active, pause_req, resp_req, fifo_req, lpi_go} = 6'h00;
    {rx_idle_start_clr, rx_wake_clr, energy_wake_clr} = 3'h0;
    link_speed = eee_pkg::SPEED_1000;
    tx_wake_wait_100 = 16'h0005;
    tx_wake_wait_1000 = 16'h0003;
    step(5);
    chk(gtx_clk_run_q, 1'b1);
    chk(phy_tx_lpi_q | deferring_q | tx_src_valid_q, 1'b0);
    resetn = 1'b1;
    step(600);
    t_tx(eee_pkg::SPEED_1000, 3);
    t_tx(eee_pkg::SPEED_100, 5);
    t_rx();
    summarize();
  end
endmodule
`default_nettype wire
